// ### event_pin_mux.sv
// Source selection for the two event pins
module event_pin_mux
  import rx_event_pkg::*;
(
  input  wire data_mode_t    mode_i,
  input  wire logic [1:0]    sel_a_i,
  input  wire logic [1:0]    sel_b_i,
  input  wire logic          addr_filt_i,
  input  wire logic          sync_i,
  input  wire logic          level_flag_i,
  input  wire logic          byte_wr_i,
  input  wire logic          not_empty_i,
  input  wire logic          frame_done_i,
  input  wire logic          addr_match_i,
  input  wire logic          bit_clk_i,
  input  wire logic          full_i,
  input  wire logic          thresh_i,
  input  wire logic          check_ok_i,
  output logic               next_pin_a_o,
  output logic               next_pin_b_o
);

  always_comb begin
    next_pin_a_o = 1'b0;
    case (mode_i)
      MODE_CONTINUOUS: next_pin_a_o = (sel_a_i == 2'h1) ? level_flag_i : sync_i;
      MODE_BUFFERED: begin
        case (sel_a_i)
          2'h1:    next_pin_a_o = byte_wr_i;
          2'h2:    next_pin_a_o = not_empty_i;
          2'h3:    next_pin_a_o = sync_i;
          default: next_pin_a_o = 1'b0;
        endcase
      end
      default: begin
        case (sel_a_i)
          2'h0:    next_pin_a_o = frame_done_i;
          2'h1:    next_pin_a_o = byte_wr_i;
          2'h2:    next_pin_a_o = not_empty_i;
          default: next_pin_a_o = addr_filt_i ? addr_match_i : sync_i;
        endcase
      end
    endcase
  end

  always_comb begin
    next_pin_b_o = 1'b0;
    if (mode_i == MODE_CONTINUOUS) begin
      next_pin_b_o = bit_clk_i;
    end else begin
      case (sel_b_i)
        2'h1:    next_pin_b_o = full_i;
        2'h2:    next_pin_b_o = level_flag_i;
        2'h3:    next_pin_b_o = thresh_i;
        default: next_pin_b_o = (mode_i == MODE_BUFFERED) ? 1'b0 : check_ok_i;
      endcase
    end
  end

endmodule : event_pin_mux

// ### rx_event_defs.svh
// Register offsets, field positions, reset values and timing counts for the receive event block
`ifndef RX_EVENT_DEFS_SVH
`define RX_EVENT_DEFS_SVH

`define EVT_SEL_QSTAT_ADDR   8'h0D
`define FILL_FLAGS_ADDR      8'h0E
`define LVL_THRESH_ADDR      8'h0F

// event_pin_select_and_queue_status fields
`define PIN_A_SEL_HI         7
`define PIN_A_SEL_LO         6
`define PIN_B_SEL_HI         5
`define PIN_B_SEL_LO         4
`define QUEUE_FULL_BIT       2
`define QUEUE_NEMPTY_N_BIT   1
`define QUEUE_OVERRUN_BIT    0

// fill_control_and_sticky_flags fields
`define FILL_METHOD_BIT      7
`define FILL_CTRL_BIT        6
`define RES_FIELD_HI         4
`define RES_FIELD_LO         3
`define LEVEL_FLAG_BIT       2
`define LOCK_FLAG_BIT        1
`define LOCK_PIN_EN_BIT      0

`define EVT_SEL_RESET        8'h00
`define FILL_FLAGS_RESET     8'h01
`define LVL_THRESH_RESET     8'h00

// Register port access latency in clock cycles
`define REG_READ_LATENCY     1

`endif

// ### rx_event_device.sv
// Receiver end: event pin routing, queue status and sticky flags
`include "rx_event_defs.svh"

module rx_event_device
  import rx_event_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                srst_i,
  rx_event_if.device               bus,
  input  wire rx_event_pkg::data_mode_t mode_i,
  input  wire logic                rx_on_i,
  input  wire logic                addr_filt_i,
  input  wire logic                sync_i,
  input  wire logic                byte_wr_i,
  input  wire logic                frame_done_i,
  input  wire logic                addr_match_i,
  input  wire logic                recovered_bit_clock_i,
  input  wire logic                check_ok_i,
  input  wire logic [7:0]          signal_level_i,
  input  wire logic                pll_lock_i,
  input  wire logic                queue_full_i,
  input  wire logic                queue_not_empty_i,
  input  wire logic                queue_thresh_i,
  input  wire logic                overrun_i,
  output logic                     queue_flush_o,
  output logic                     queue_fill_en_o
);
  import rx_event_pkg::*;

  // ==========================================================
  // Register state
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic       overrun_flag;
  logic       fill_method;
  logic       fill_ctrl;
  logic [1:0] res_bits;
  logic       signal_level_flag;
  logic       lock_flag;
  logic       lock_pin_en;
  logic [7:0] signal_level_threshold;
  logic       next_pin_a;
  logic       next_pin_b;
  logic       wr_sel;
  logic       wr_fill;
  logic       wr_thr;
  logic       level_hit;
  logic       full_src;
  logic       nempty_src;
  logic       thresh_src;

  // Reset images of the two mixed registers, so fields are cut by position
  localparam logic [7:0] SEL_RST  = `EVT_SEL_RESET;
  localparam logic [7:0] FILL_RST = `FILL_FLAGS_RESET;

  assign wr_sel    = bus.reg_wr && (bus.reg_addr == `EVT_SEL_QSTAT_ADDR);
  assign wr_fill   = bus.reg_wr && (bus.reg_addr == `FILL_FLAGS_ADDR);
  assign wr_thr    = bus.reg_wr && (bus.reg_addr == `LVL_THRESH_ADDR);
  assign level_hit = signal_level_i > signal_level_threshold;

  // Queue sources stay valid regardless of rx_on_i so the host can drain in standby
  assign full_src   = queue_full_i;
  assign nempty_src = queue_not_empty_i;
  assign thresh_src = queue_thresh_i;

  // ==========================================================
  // Selector and configuration bits
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sel_a <= SEL_RST[`PIN_A_SEL_HI:`PIN_A_SEL_LO];
      sel_b <= SEL_RST[`PIN_B_SEL_HI:`PIN_B_SEL_LO];
    end else if (wr_sel) begin
      sel_a <= bus.reg_wdata[`PIN_A_SEL_HI:`PIN_A_SEL_LO];
      sel_b <= bus.reg_wdata[`PIN_B_SEL_HI:`PIN_B_SEL_LO];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fill_method <= FILL_RST[`FILL_METHOD_BIT];
      res_bits    <= FILL_RST[`RES_FIELD_HI:`RES_FIELD_LO];
      lock_pin_en <= FILL_RST[`LOCK_PIN_EN_BIT];
    end else if (wr_fill) begin
      fill_method <= bus.reg_wdata[`FILL_METHOD_BIT];
      res_bits    <= bus.reg_wdata[`RES_FIELD_HI:`RES_FIELD_LO];
      lock_pin_en <= bus.reg_wdata[`LOCK_PIN_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      signal_level_threshold <= `LVL_THRESH_RESET;
    end else if (wr_thr) begin
      signal_level_threshold <= bus.reg_wdata;
    end
  end

  // ==========================================================
  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      overrun_flag <= 1'b0;
    end else if (overrun_i) begin
      overrun_flag <= 1'b1;
    end else if (wr_sel && bus.reg_wdata[`QUEUE_OVERRUN_BIT]) begin
      overrun_flag <= 1'b0;
    end
  end

  // Flush pulse accompanies the overrun clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      queue_flush_o <= 1'b0;
    end else begin
      queue_flush_o <= wr_sel && bus.reg_wdata[`QUEUE_OVERRUN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      signal_level_flag <= 1'b0;
    end else if (level_hit && rx_on_i) begin
      signal_level_flag <= 1'b1;
    end else if (wr_fill && bus.reg_wdata[`LEVEL_FLAG_BIT]) begin
      signal_level_flag <= 1'b0;
    end
  end

  // Set tracks the rising edge of lock so a cleared bit stays clear while lock holds
  logic pll_lock_d;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pll_lock_d <= 1'b0;
      lock_flag  <= 1'b0;
    end else begin
      pll_lock_d <= pll_lock_i;
      if (pll_lock_i && !pll_lock_d) begin
        lock_flag <= 1'b1;
      end else if (!pll_lock_i) begin
        lock_flag <= 1'b0;
      end else if (wr_fill && bus.reg_wdata[`LOCK_FLAG_BIT]) begin
        lock_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Fill control
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fill_ctrl <= 1'b0;
    end else if (fill_method) begin
      if (wr_fill) begin
        fill_ctrl <= bus.reg_wdata[`FILL_CTRL_BIT];
      end
    end else if (sync_i && !fill_ctrl && mode_i == MODE_BUFFERED) begin
      fill_ctrl <= 1'b1;
    end else if (wr_fill && bus.reg_wdata[`FILL_CTRL_BIT] && !overrun_flag) begin
      fill_ctrl <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      queue_fill_en_o <= 1'b0;
    end else begin
      queue_fill_en_o <= (mode_i == MODE_BUFFERED) ? fill_ctrl : rx_on_i;
    end
  end

  // ==========================================================
  // Event pins
  event_pin_mux u_mux (
    .mode_i       (mode_i),
    .sel_a_i      (sel_a),
    .sel_b_i      (sel_b),
    .addr_filt_i  (addr_filt_i),
    .sync_i       (sync_i),
    .level_flag_i (signal_level_flag),
    .byte_wr_i    (byte_wr_i),
    .not_empty_i  (nempty_src),
    .frame_done_i (frame_done_i),
    .addr_match_i (addr_match_i),
    .bit_clk_i    (recovered_bit_clock_i),
    .full_i       (full_src),
    .thresh_i     (thresh_src),
    .check_ok_i   (check_ok_i),
    .next_pin_a_o (next_pin_a),
    .next_pin_b_o (next_pin_b)
  );

  // One register stage only, so outputs stay flop-driven; sticky flags hold until cleared
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus.pin_a       <= 1'b0;
      bus.pin_b       <= 1'b0;
      bus.lock_pin_o  <= 1'b0;
      bus.lock_pin_oe <= 1'b0;
    end else begin
      bus.pin_a       <= next_pin_a;
      bus.pin_b       <= next_pin_b;
      bus.lock_pin_o  <= lock_flag;
      bus.lock_pin_oe <= lock_pin_en;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus.reg_rdata  <= 8'h00;
      bus.reg_rvalid <= 1'b0;
    end else begin
      bus.reg_rvalid <= bus.reg_rd;
      case (bus.reg_addr)
        `EVT_SEL_QSTAT_ADDR: bus.reg_rdata <= {sel_a, sel_b, 1'b0,
                                               queue_full_i,
                                               queue_not_empty_i,
                                               overrun_flag};
        `FILL_FLAGS_ADDR:    bus.reg_rdata <= {fill_method, fill_ctrl, 1'b0, res_bits,
                                               signal_level_flag, lock_flag, lock_pin_en};
        `LVL_THRESH_ADDR:    bus.reg_rdata <= signal_level_threshold;
        default:             bus.reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : rx_event_device

// ### rx_event_host.sv
// Host end: drives register port, returns read data and samples event pins
`include "rx_event_defs.svh"

module rx_event_host
  import rx_event_pkg::*;
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  rx_event_if.host                      bus,
  input  wire logic                     req_wr_i,
  input  wire logic                     req_rd_i,
  input  wire rx_event_pkg::reg_addr_t  req_addr_i,
  input  wire rx_event_pkg::reg_byte_t  req_wdata_i,
  output rx_event_pkg::reg_byte_t       rdata_o,
  output logic                          rdata_valid_o,
  output logic                          pin_a_o,
  output logic                          pin_b_o,
  output logic                          lock_o
);
  import rx_event_pkg::*;

  // ==========================================================
  // Request issue; manual fill start/stop is a plain write of bit 6
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_addr  <= 8'h00;
      bus.reg_wdata <= 8'h00;
    end else begin
      bus.reg_wr    <= req_wr_i;
      bus.reg_rd    <= req_rd_i && !req_wr_i;
      bus.reg_addr  <= req_addr_i;
      bus.reg_wdata <= req_wdata_i;
    end
  end

  // ==========================================================
  // Answers and pin sampling
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o       <= 8'h00;
      rdata_valid_o <= 1'b0;
      pin_a_o       <= 1'b0;
      pin_b_o       <= 1'b0;
      lock_o        <= 1'b0;
    end else begin
      rdata_valid_o <= bus.reg_rvalid;
      if (bus.reg_rvalid) begin
        rdata_o <= bus.reg_rdata;
      end
      pin_a_o <= bus.pin_a;
      pin_b_o <= bus.pin_b;
      lock_o  <= bus.lock_pin;
    end
  end

endmodule : rx_event_host

// ### rx_event_if.sv
// Register port and event pins between receiver and host
interface rx_event_if;
  import rx_event_pkg::*;

  logic      reg_wr;
  logic      reg_rd;
  reg_addr_t reg_addr;
  reg_byte_t reg_wdata;
  reg_byte_t reg_rdata;
  logic      reg_rvalid;
  logic      pin_a;
  logic      pin_b;
  logic      lock_pin_o;
  logic      lock_pin_oe;
  logic      lock_pin;

  // Wire level of the lock pin; floats to 0 for simulation when not driven
  assign lock_pin = lock_pin_oe ? lock_pin_o : 1'b0;

  modport device (
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid, pin_a, pin_b, lock_pin_o, lock_pin_oe
  );

  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, reg_rvalid, pin_a, pin_b, lock_pin
  );
endinterface : rx_event_if

// ### rx_event_pkg.sv
// Types shared by both ends of the receive event link
package rx_event_pkg;

  typedef enum logic [1:0] {
    MODE_CONTINUOUS = 2'b00,
    MODE_BUFFERED   = 2'b01,
    MODE_PACKET     = 2'b10,
    MODE_PACKET_ALT = 2'b11
  } data_mode_t;

  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;

endpackage : rx_event_pkg

// ### rx_event_sva.sv
// Register port and lock pin checks for the receive event link
`include "rx_event_defs.svh"
module rx_event_sva (
  input wire logic                    sys_clk_i,
  input wire logic                    srst_i,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire rx_event_pkg::reg_addr_t reg_addr,
  input wire rx_event_pkg::reg_byte_t reg_wdata,
  input wire rx_event_pkg::reg_byte_t reg_rdata,
  input wire logic                    reg_rvalid,
  input wire logic                    pin_a,
  input wire logic                    pin_b,
  input wire logic                    lock_pin_oe
);
  import rx_event_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  // ========================================
  // Shadows of host-written fields
  logic [3:0] sel;
  logic [3:0] cfg;
  reg_byte_t  thr;
  logic       wr_e;
  assign wr_e = reg_wr && reg_addr == `FILL_FLAGS_ADDR;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sel <= 4'h0;
      cfg <= 4'h1;
      thr <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `EVT_SEL_QSTAT_ADDR: sel <= reg_wdata[7:4];
        `FILL_FLAGS_ADDR: cfg <= {reg_wdata[7], reg_wdata[4:3], reg_wdata[0]};
        `LVL_THRESH_ADDR: thr <= reg_wdata;
        default: ;
      endcase
    end
  end
  // ========================================
  // Assertions
  property p_rvalid;
    reg_rvalid == $past(reg_rd);
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read valid not one cycle after read");
  property p_sel;
    reg_rvalid && $past(reg_addr) == `EVT_SEL_QSTAT_ADDR
      |-> reg_rdata[7:4] == $past(sel) && !reg_rdata[3];
  endproperty
  a_sel: assert property (p_sel)
    else $error("pin selector readback wrong");
  property p_cfg;
    reg_rvalid && $past(reg_addr) == `FILL_FLAGS_ADDR
      |-> {reg_rdata[7], reg_rdata[4:3], reg_rdata[0]} == $past(cfg) && !reg_rdata[5];
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("fill method or lock enable readback wrong");
  property p_thr;
    reg_rvalid && $past(reg_addr) == `LVL_THRESH_ADDR |-> reg_rdata == $past(thr);
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold readback wrong");
  property p_unmapped;
    reg_rvalid && ($past(reg_addr) < `EVT_SEL_QSTAT_ADDR || $past(reg_addr) > `LVL_THRESH_ADDR)
      |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_oe_follow;
    $changed(cfg[0]) |-> ##[0:2] lock_pin_oe == cfg[0];
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("lock pin enable ignores write");
  property p_oe_cause;
    $changed(lock_pin_oe) |-> $past(wr_e) || $past(wr_e, 2) || $past(srst_i) || $past(srst_i, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("lock pin enable changed unprompted");
  property p_oe_reset;
    $fell(srst_i) |-> ##[0:1] lock_pin_oe;
  endproperty
  a_oe_reset: assert property (p_oe_reset)
    else $error("lock pin not driven after reset");
  c_rd_flags: cover property (reg_rvalid && $past(reg_addr) == `FILL_FLAGS_ADDR);
  c_oe_off: cover property ($fell(lock_pin_oe));
  c_pin_a: cover property ($rose(pin_a));
  c_pin_b: cover property ($rose(pin_b));
endmodule : rx_event_sva

// ### testbench.sv
// Self-checking bench joining both ends of the receive event link
`include "rx_event_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import rx_event_pkg::*;
  localparam reg_addr_t A_SEL = `EVT_SEL_QSTAT_ADDR;
  localparam reg_addr_t A_FIL = `FILL_FLAGS_ADDR;
  localparam reg_addr_t A_THR = `LVL_THRESH_ADDR;
  logic       sys_clk = 1'b0;
  logic       srst = 1'b1;
  logic       req_wr = 1'b0;
  logic       req_rd = 1'b0;
  reg_addr_t  req_addr = 8'h00;
  reg_byte_t  req_wdata = 8'h00;
  data_mode_t mode = MODE_CONTINUOUS;
  logic       rx_on = 1'b0;
  logic       filt = 1'b0;
  logic [9:0] src = 10'h000;
  reg_byte_t  lvl = 8'h00;
  logic       lock = 1'b0;
  reg_byte_t  rdata;
  logic       rvalid, pa, pb, lk, flush, fill_en;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         n_flush = 0;
  rx_event_if bus_if ();
  rx_event_device rx_event_device_inst (
    .sys_clk_i(sys_clk), .srst_i(srst), .bus(bus_if), .mode_i(mode), .rx_on_i(rx_on),
    .addr_filt_i(filt), .sync_i(src[0]), .byte_wr_i(src[1]), .frame_done_i(src[3]),
    .addr_match_i(src[4]), .recovered_bit_clock_i(src[5]), .check_ok_i(src[8]),
    .signal_level_i(lvl), .pll_lock_i(lock), .queue_full_i(src[6]),
    .queue_not_empty_i(src[2]), .queue_thresh_i(src[7]), .overrun_i(src[9]),
    .queue_flush_o(flush), .queue_fill_en_o(fill_en));
  rx_event_host rx_event_host_inst (
    .sys_clk_i(sys_clk), .srst_i(srst), .bus(bus_if), .req_wr_i(req_wr), .req_rd_i(req_rd),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .rdata_o(rdata),
    .rdata_valid_o(rvalid), .pin_a_o(pa), .pin_b_o(pb), .lock_o(lk));
  rx_event_sva rx_event_sva_inst (
    .sys_clk_i(sys_clk), .srst_i(srst), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .reg_rvalid(bus_if.reg_rvalid), .pin_a(bus_if.pin_a), .pin_b(bus_if.pin_b),
    .lock_pin_oe(bus_if.lock_pin_oe));
  always #2.5 sys_clk = ~sys_clk;
  // Counted mid-cycle so the one-cycle pulse is seen exactly once
  always @(negedge sys_clk) begin
    if (flush === 1'b1) n_flush++;
  end
  // ========================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge sys_clk);
    req_wr <= 1'b1;
    req_addr <= a;
    req_wdata <= d;
    @(posedge sys_clk);
    req_wr <= 1'b0;
    tick(2);
  endtask : wr
  task automatic rd(input reg_addr_t a, input reg_byte_t e);
    int n;
    @(posedge sys_clk);
    req_rd <= 1'b1;
    req_addr <= a;
    @(posedge sys_clk);
    req_rd <= 1'b0;
    #1;
    for (n = 0; n < 8 && rvalid !== 1'b1; n++) tick(1);
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask : rd
  // Single-cycle event on one source line
  task automatic pulse(input int b);
    @(posedge sys_clk);
    src[b] <= 1'b1;
    @(posedge sys_clk);
    src[b] <= 1'b0;
  endtask : pulse
  function automatic logic exp_a(input int m, input int s, input logic f, input logic [8:0] v);
    if (m == 0) return s == 1 ? 1'b0 : v[0];
    if (m == 1) return s == 0 ? 1'b0 : v[s == 3 ? 0 : s];
    return s == 0 ? v[3] : s == 3 ? v[f ? 4 : 0] : v[s];
  endfunction : exp_a
  function automatic logic exp_b(input int m, input int s, input logic [8:0] v);
    if (m == 0) return v[5];
    if (s == 0) return m == 1 ? 1'b0 : v[8];
    return s == 1 ? v[6] : s == 3 ? v[7] : 1'b0;
  endfunction : exp_b
  // ========================================
  // Scenarios
  task automatic t_reset();
    rd(A_SEL, 8'h00);
    rd(A_FIL, 8'h01);
    rd(A_THR, 8'h00);
    rd(8'h10, 8'h00);
    chk(bus_if.lock_pin_oe, 1'b1);
    wr(A_THR, 8'hA5);
    rd(A_THR, 8'hA5);
  endtask : t_reset
  // Standby throughout, so queue sources must still reach the pins
  task automatic t_walk();
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        for (int f = 0; f < 2; f++) begin
          @(posedge sys_clk);
          mode <= data_mode_t'(m[1:0]);
          filt <= f[0];
          wr(A_SEL, {s[1:0], s[1:0], 4'h0});
          for (int k = 0; k < 9; k++) begin
            @(posedge sys_clk);
            src <= 10'h001 << k;
            tick(3);
            chk(pa, exp_a(m, s, f[0], 9'h001 << k));
            chk(pb, exp_b(m, s, 9'h001 << k));
          end
        end
      end
    end
    @(posedge sys_clk);
    src <= 10'h000;
  endtask : t_walk
  task automatic t_level();
    wr(A_FIL, 8'h41);
    wr(A_THR, 8'h80);
    wr(A_SEL, 8'h60);
    @(posedge sys_clk);
    mode <= MODE_CONTINUOUS;
    rx_on <= 1'b1;
    lvl <= 8'h80;
    tick(4);
    chk(pa, 1'b0);
    @(posedge sys_clk);
    lvl <= 8'h81;
    tick(4);
    chk(bus_if.pin_a, 1'b1);
    rd(A_FIL, 8'h05);
    @(posedge sys_clk);
    lvl <= 8'h00;
    mode <= MODE_PACKET;
    tick(4);
    chk(pb, 1'b1);
    wr(A_FIL, 8'h05);
    rd(A_FIL, 8'h01);
    chk(pb, 1'b0);
    @(posedge sys_clk);
    rx_on <= 1'b0;
  endtask : t_level
  task automatic t_queue();
    wr(A_SEL, 8'h00);
    @(posedge sys_clk);
    src <= 10'h044;
    rd(A_SEL, 8'h06);
    wr(A_SEL, 8'h06);
    rd(A_SEL, 8'h06);
    pulse(9);
    rd(A_SEL, 8'h07);
    wr(A_SEL, 8'h01);
    chk(n_flush[7:0], 8'h01);
    rd(A_SEL, 8'h06);
    @(posedge sys_clk);
    src <= 10'h000;
    rd(A_SEL, 8'h00);
  endtask : t_queue
  task automatic t_fill();
    @(posedge sys_clk);
    mode <= MODE_BUFFERED;
    wr(A_FIL, 8'h41);
    rd(A_FIL, 8'h01);
    chk(fill_en, 1'b0);
    pulse(0);
    rd(A_FIL, 8'h41);
    chk(fill_en, 1'b1);
    pulse(9);
    wr(A_FIL, 8'h41);
    rd(A_FIL, 8'h41);
    wr(A_SEL, 8'h01);
    wr(A_FIL, 8'h41);
    rd(A_FIL, 8'h01);
    // Method takes effect one cycle after its write, so select manual first
    wr(A_FIL, 8'h81);
    wr(A_FIL, 8'hC1);
    rd(A_FIL, 8'hC1);
    chk(fill_en, 1'b1);
    wr(A_FIL, 8'h81);
    rd(A_FIL, 8'h81);
    chk(fill_en, 1'b0);
    chk(n_flush[7:0], 8'h02);
  endtask : t_fill
  task automatic t_lock();
    wr(A_FIL, 8'h01);
    @(posedge sys_clk);
    lock <= 1'b1;
    tick(4);
    rd(A_FIL, 8'h03);
    chk(lk, 1'b1);
    wr(A_FIL, 8'h03);
    rd(A_FIL, 8'h01);
    wr(A_FIL, 8'h00);
    chk(bus_if.lock_pin_oe, 1'b0);
    rd(A_FIL, 8'h00);
    // Relock with the pin released: flag sets, pin must stay undriven
    @(posedge sys_clk);
    lock <= 1'b0;
    tick(2);
    @(posedge sys_clk);
    lock <= 1'b1;
    tick(4);
    rd(A_FIL, 8'h02);
    chk(lk, 1'b0);
    @(posedge sys_clk);
    lock <= 1'b0;
  endtask : t_lock
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_walk();
    t_level();
    t_queue();
    t_fill();
    t_lock();
    end_of_test();
  end
  // Whole run needs about 1500 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : testbench
